// [rtl/mcf_regs.svh]
// Register map, field positions, reset values and timing figures of the fan monitor
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH

// ==========================================================================
// Register offsets
`define MCF_ADDR_CONFIG_ONE   8'h00
`define MCF_ADDR_DAC_CODE     8'h04
`define MCF_ADDR_PWM_DUTY     8'h05
`define MCF_ADDR_START_FIRST  8'h10
`define MCF_ADDR_START_SECOND 8'h11
`define MCF_ADDR_START_THIRD  8'h12
`define MCF_ADDR_TEST_ONE     8'h14
`define MCF_ADDR_SHARED_A     8'h27
`define MCF_ADDR_SHARED_B     8'h29
`define MCF_ADDR_STATUS       8'h44
`define MCF_ADDR_VALUE_BASE   8'h30
`define MCF_ADDR_HIGH_BASE    8'h50
`define MCF_ADDR_LOW_BASE     8'h70

// ==========================================================================
// Field positions
`define MCF_CFG_START         0
`define MCF_CFG_INT_EN        1
`define MCF_CFG_INT_CLR       2
`define MCF_CFG_SHARED_DIODE  3
`define MCF_CFG_AUTO_DAC      5
`define MCF_CFG_AUTO_PWM      6
`define MCF_TEST_PWM_INVERT   1
`define MCF_STAT_LIMIT        0
`define MCF_STAT_FAN          1

// ==========================================================================
// Reset values
`define MCF_RST_CONFIG        8'h00
`define MCF_RST_DAC           8'hff
`define MCF_RST_PWM           8'hff
`define MCF_RST_START_TEMP    8'h7f
`define MCF_RST_TEST          8'h00
`define MCF_RST_HIGH          8'hff
`define MCF_RST_LOW           8'h00

// ==========================================================================
// Channel order
`define MCF_CH_COUNT          20
`define MCF_CH_REMOTE_ONE     5'h00
`define MCF_CH_ANALOG_EIGHT   5'h09
`define MCF_CH_ANALOG_NINE    5'h0a
`define MCF_CH_REMOTE_TWO     5'h12
`define MCF_CH_LOCAL          5'h13

// ==========================================================================
// Timing and transfer law
`define MCF_CLK_HZ            40000000
`define MCF_FAST_CONV_NS      711000
`define MCF_SLOW_CONV_NS      2130000
`define MCF_SPINUP_MS         2000
`define MCF_PWM_HZ            75
`define MCF_PWM_STEPS         255
`define MCF_SAMPLES_LAST      4'hf
`define MCF_RAMP_DEG          9'h014
`define MCF_HYST_DEG          9'h004
`define MCF_DAC_TOP           8'hf0
`define MCF_FULL_DRIVE        8'hff
`define MCF_DAC_STEP          8'h10
`define MCF_PWM_STEP          8'h11
`define MCF_DIFF_IGNORE       9'h180

`endif

// [rtl/mcf_pkg.sv]
// Types shared by the fan monitor design
package mcf_pkg;

	typedef enum logic [1:0] {
		MCF_SEQ_IDLE    = 2'b00,
		MCF_SEQ_CONVERT = 2'b01
	} mcf_seq_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mcf_reg_req_t;

endpackage

// [rtl/mcf_monitor_fan.sv]
// Monitoring sequencer, averaging, limits and automatic fan drive
// Contract
// - Monitoring runs while start bit 0 is one and clear bit 2 is zero.
// - Interrupt pin is pulled low only while enable bit 1 is set.
// - Channels convert in turn, remote one first, local last, each stored unless the shared pin mode discards it.
// - Sequence repeats until start bit is cleared; latest values stay readable.
// - Shared pin pair is converted both as two analog and one remote channel.
// - Analog mode keeps 27h and 29h, diode mode keeps temperature at 29h.
// - Each conversion lasts 711 us, remote temperature ones 2.13 ms.
// - Sixteen conversions per channel are averaged into the result.
// - Sequencing is timed on its own counter, independent of fan measurement.
// - Voltage beyond high or low limit, temperature over hot limit, flags interrupt.
// - Fan DAC code register at 04h resets to ffh.
// - Open-drain pulse output near 75 Hz, duty from 05h unless automatic.
// - Test bit 1 at 14h inverts the pulse output polarity.
// - Bits 5 and 6 enable automatic drive of DAC and pulse outputs.
// - Three signed start temperatures at 10h to 12h, one per sensor.
// - Floors come from upper nibbles; DAC nibble serves both when both on.
// - DAC floor is sixteen times nibble, duty floor 6.67 percent per step.
// - Any sensor above start runs full drive two seconds, then the ramp law from floor.
// - Drive ramps linearly to 240 or full duty over 20 degrees, then full.
// - The sensor demanding most drive sets the fan drive.
// - Fan stops only when all sensors are 4 degrees below start.
// - Each automatic fan start or stop raises one interrupt event.
`timescale 1ns/1ps
`default_nettype none
`include "mcf_regs.svh"

module mcf_monitor_fan #(
	parameter int unsigned FAST_CONV_CYC = (`MCF_FAST_CONV_NS / 1000) * (`MCF_CLK_HZ / 1000000),
	parameter int unsigned SLOW_CONV_CYC = (`MCF_SLOW_CONV_NS / 1000) * (`MCF_CLK_HZ / 1000000),
	parameter int unsigned SPINUP_CYC    = `MCF_SPINUP_MS * (`MCF_CLK_HZ / 1000)
) (
	input  wire logic                 ref_clk,    // 40 MHz clock
	input  wire logic                 rst,        // Synchronous reset, active high
	input  wire logic                 clk_en,     // Freezes all state when low
	input  wire mcf_pkg::mcf_reg_req_t reg_req,   // Register write/read request
	output logic [7:0]                reg_rdata,  // Read data, valid after rd
	input  wire logic [7:0]           adc_data,   // Converter result for adc_chan
	output logic [4:0]                adc_chan,   // Channel being converted
	output logic                      adc_sample, // Pulse: adc_data was taken
	output logic [7:0]                dac_code,   // Fan DAC code
	output logic                      pwm_o,      // Pulse pin output level
	output logic                      pwm_oe,     // Pulse pin pulled low
	output logic                      int_n_o,    // Interrupt pin output level
	output logic                      int_n_oe,   // Interrupt pin pulled low
	output logic                      fan_running // Automatic fan on
);

	localparam int unsigned PWM_STEP_CYC = `MCF_CLK_HZ / (`MCF_PWM_HZ * `MCF_PWM_STEPS);

	// ==========================================================================
	// Functions
	function automatic logic is_temp(input logic [4:0] ch);
		return (ch == `MCF_CH_REMOTE_ONE) || (ch == `MCF_CH_REMOTE_TWO) || (ch == `MCF_CH_LOCAL);
	endfunction

	function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base);
		return (addr >= base) && (addr < base + 8'(`MCF_CH_COUNT));
	endfunction

	function automatic logic signed [8:0] temp_diff(input logic [7:0] t, input logic [7:0] s);
		return $signed({t[7], t}) - $signed({s[7], s});
	endfunction

	// Truncating interpolation; above the ramp the output jumps to full scale
	function automatic logic [7:0] ramp(input logic [7:0] floor, input logic [7:0] top,
			input logic signed [8:0] diff);
		logic [15:0] prod;
		prod = 16'(top - floor) * {8'h00, diff[7:0]};
		if (diff > $signed(`MCF_RAMP_DEG))
			return `MCF_FULL_DRIVE;
		else if (diff <= 9'sd0)
			return floor;
		else
			return floor + 8'(prod / 16'(`MCF_RAMP_DEG));
	endfunction

	// ==========================================================================
	// Registers
	logic [7:0] config_one, fan_dac_code, fan_pwm_duty, test_control_one;
	logic [7:0] fan_start_temp [3];
	logic [7:0] shared_analog_value, shared_temp_or_analog_value;
	logic [7:0] value    [`MCF_CH_COUNT];
	logic [7:0] high_lim [`MCF_CH_COUNT];
	logic [7:0] low_lim  [`MCF_CH_COUNT];
	logic [1:0] status;

	mcf_pkg::mcf_seq_state_t state;
	logic [31:0] conv_cnt, slot_len, spin_cnt;
	logic [3:0]  samp;
	logic [11:0] acc, next_acc;
	logic        done, recalc, fan_on, fan_event, limit_hit;
	logic [4:0]  done_ch;
	logic [7:0]  done_val;
	logic        run, diode_mode, auto_dac, auto_pwm, slot_end, keep;
	logic signed [8:0] diff_loc, diff_r1, diff_r2, max_diff, max_hold;
	logic        any_hot, all_cool, spinning, pwm_active;
	logic [7:0]  pwm_duty, dac_floor, pwm_floor;
	logic [11:0] pwm_pre;
	logic [7:0]  pwm_phase;

	assign run        = config_one[`MCF_CFG_START] && !config_one[`MCF_CFG_INT_CLR];
	assign diode_mode = config_one[`MCF_CFG_SHARED_DIODE];
	assign auto_dac   = config_one[`MCF_CFG_START] && config_one[`MCF_CFG_AUTO_DAC];
	assign auto_pwm   = config_one[`MCF_CFG_START] && config_one[`MCF_CFG_AUTO_PWM];
	assign slot_len   = is_temp(adc_chan) && adc_chan != `MCF_CH_LOCAL ?
		SLOW_CONV_CYC : FAST_CONV_CYC;
	assign slot_end   = (conv_cnt == slot_len - 32'd1);
	assign next_acc   = acc + (is_temp(adc_chan) ? {{4{adc_data[7]}}, adc_data} :
		{4'h0, adc_data});

	// ==========================================================================
	// Round-robin sequencer, own slot timer so no fan loop coupling
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state      <= mcf_pkg::MCF_SEQ_IDLE;
			adc_chan   <= `MCF_CH_REMOTE_ONE;
			conv_cnt   <= 32'd0;
			samp       <= 4'h0;
			acc        <= 12'h000;
			adc_sample <= 1'b0;
			done       <= 1'b0;
			done_ch    <= `MCF_CH_REMOTE_ONE;
			done_val   <= 8'h00;
		end else if (clk_en) begin
			adc_sample <= 1'b0;
			done       <= 1'b0;
			case (state)
				mcf_pkg::MCF_SEQ_IDLE: begin
					if (run) begin
						state    <= mcf_pkg::MCF_SEQ_CONVERT;
						adc_chan <= `MCF_CH_REMOTE_ONE;
						conv_cnt <= 32'd0;
						samp     <= 4'h0;
						acc      <= 12'h000;
					end
				end
				mcf_pkg::MCF_SEQ_CONVERT: begin
					if (!run) begin
						state <= mcf_pkg::MCF_SEQ_IDLE;
					end else if (slot_end) begin
						conv_cnt   <= 32'd0;
						adc_sample <= 1'b1;
						samp       <= samp + 4'h1;
						if (samp == `MCF_SAMPLES_LAST) begin
							acc      <= 12'h000;
							done     <= 1'b1;
							done_ch  <= adc_chan;
							done_val <= next_acc[11:4];
							// Shared pins get both their analog and diode slots
							adc_chan <= (adc_chan == `MCF_CH_LOCAL) ?
								`MCF_CH_REMOTE_ONE : adc_chan + 5'h01;
						end else begin
							acc <= next_acc;
						end
					end else begin
						conv_cnt <= conv_cnt + 32'd1;
					end
				end
				default: state <= mcf_pkg::MCF_SEQ_IDLE;
			endcase
		end
	end

	// ==========================================================================
	// Result storage with shared pin routing
	always_comb begin
		keep = 1'b1;
		if (done_ch == `MCF_CH_REMOTE_TWO)
			keep = diode_mode;
		else if (done_ch == `MCF_CH_ANALOG_EIGHT || done_ch == `MCF_CH_ANALOG_NINE)
			keep = !diode_mode;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shared_analog_value         <= 8'h00;
			shared_temp_or_analog_value <= 8'h00;
			for (int i = 0; i < `MCF_CH_COUNT; i++)
				value[i] <= 8'h00;
		end else if (clk_en && done && keep) begin
			value[done_ch] <= done_val;
			if (done_ch == `MCF_CH_ANALOG_EIGHT)
				shared_analog_value <= done_val;
			if (done_ch == `MCF_CH_ANALOG_NINE || done_ch == `MCF_CH_REMOTE_TWO)
				shared_temp_or_analog_value <= done_val;
		end
	end

	// Temperatures compare signed against hot limit only; hysteresis limit is for software
	assign limit_hit = done && keep && (is_temp(done_ch) ?
		$signed(done_val) > $signed(high_lim[done_ch]) :
		(done_val > high_lim[done_ch] || done_val < low_lim[done_ch]));

	// ==========================================================================
	// Sticky interrupt flags; a new event beats the clear bit
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status   <= 2'b00;
			int_n_oe <= 1'b0;
			int_n_o  <= 1'b0;
		end else if (clk_en) begin
			status <= (status & ~{2{config_one[`MCF_CFG_INT_CLR]}}) |
				{fan_event, limit_hit};
			int_n_oe <= config_one[`MCF_CFG_INT_EN] && (status != 2'b00);
		end
	end

	// ==========================================================================
	// Automatic control: highest demand wins, start/stop with hysteresis
	always_comb begin
		diff_loc = temp_diff(value[`MCF_CH_LOCAL], fan_start_temp[0]);
		diff_r1  = temp_diff(value[`MCF_CH_REMOTE_ONE], fan_start_temp[1]);
		diff_r2  = diode_mode ? temp_diff(value[`MCF_CH_REMOTE_TWO], fan_start_temp[2]) :
			$signed(`MCF_DIFF_IGNORE);
		max_diff = diff_loc;
		if (diff_r1 > max_diff)
			max_diff = diff_r1;
		if (diff_r2 > max_diff)
			max_diff = diff_r2;
		any_hot  = max_diff > 9'sd0;
		all_cool = max_diff <= -$signed(`MCF_HYST_DEG);
	end

	assign spinning = (spin_cnt != 32'd0);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			recalc    <= 1'b0;
			fan_on    <= 1'b0;
			fan_event <= 1'b0;
			spin_cnt  <= 32'd0;
			max_hold  <= 9'sd0;
		end else if (clk_en) begin
			recalc    <= done && keep && is_temp(done_ch);
			fan_event <= 1'b0;
			if (!(auto_dac || auto_pwm)) begin
				fan_on   <= 1'b0;
				spin_cnt <= 32'd0;
			end else if (recalc && !fan_on && any_hot) begin
				fan_on    <= 1'b1;
				fan_event <= 1'b1;
				spin_cnt  <= SPINUP_CYC;
				max_hold  <= max_diff;
			end else if (recalc && fan_on && all_cool) begin
				fan_on    <= 1'b0;
				fan_event <= 1'b1;
				spin_cnt  <= 32'd0;
				max_hold  <= max_diff;
			end else begin
				if (recalc)
					max_hold <= max_diff;
				if (spinning)
					spin_cnt <= spin_cnt - 32'd1;
			end
		end
	end

	assign fan_running = fan_on;

	// ==========================================================================
	// Output drive selection
	assign dac_floor = 8'(fan_dac_code[7:4] * `MCF_DAC_STEP);
	assign pwm_floor = 8'((auto_dac ? fan_dac_code[7:4] : fan_pwm_duty[7:4]) *
		`MCF_PWM_STEP);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dac_code <= `MCF_RST_DAC;
			pwm_duty <= `MCF_RST_PWM;
		end else if (clk_en) begin
			if (!auto_dac)
				dac_code <= fan_dac_code;
			else if (!fan_on)
				dac_code <= 8'h00;
			else if (spinning)
				dac_code <= `MCF_FULL_DRIVE;
			else
				dac_code <= ramp(dac_floor, `MCF_DAC_TOP, max_hold);
			if (!auto_pwm)
				pwm_duty <= fan_pwm_duty;
			else if (!fan_on)
				pwm_duty <= 8'h00;
			else if (spinning)
				pwm_duty <= `MCF_FULL_DRIVE;
			else
				pwm_duty <= ramp(pwm_floor, `MCF_FULL_DRIVE, max_hold);
		end
	end

	// ==========================================================================
	// Pulse output: 255 steps per period; with test bit 1 clear a released pin means drive on
	assign pwm_active = (pwm_duty > pwm_phase);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_pre   <= 12'h000;
			pwm_phase <= 8'h00;
			pwm_oe    <= 1'b1;
			pwm_o     <= 1'b0;
		end else if (clk_en) begin
			if (pwm_pre == 12'(PWM_STEP_CYC - 1)) begin
				pwm_pre   <= 12'h000;
				pwm_phase <= (pwm_phase == 8'(`MCF_PWM_STEPS - 1)) ? 8'h00 : pwm_phase + 8'h01;
			end else begin
				pwm_pre <= pwm_pre + 12'h001;
			end
			pwm_oe <= !(pwm_active ^ test_control_one[`MCF_TEST_PWM_INVERT]);
		end
	end

	// ==========================================================================
	// Register access
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			config_one       <= `MCF_RST_CONFIG;
			fan_dac_code     <= `MCF_RST_DAC;
			fan_pwm_duty     <= `MCF_RST_PWM;
			test_control_one <= `MCF_RST_TEST;
			for (int i = 0; i < 3; i++)
				fan_start_temp[i] <= `MCF_RST_START_TEMP;
			for (int i = 0; i < `MCF_CH_COUNT; i++) begin
				high_lim[i] <= `MCF_RST_HIGH;
				low_lim[i]  <= `MCF_RST_LOW;
			end
		end else if (clk_en && reg_req.wr) begin
			case (reg_req.addr)
				`MCF_ADDR_CONFIG_ONE:   config_one        <= reg_req.wdata;
				`MCF_ADDR_DAC_CODE:     fan_dac_code      <= reg_req.wdata;
				`MCF_ADDR_PWM_DUTY:     fan_pwm_duty      <= reg_req.wdata;
				`MCF_ADDR_START_FIRST:  fan_start_temp[0] <= reg_req.wdata;
				`MCF_ADDR_START_SECOND: fan_start_temp[1] <= reg_req.wdata;
				`MCF_ADDR_START_THIRD:  fan_start_temp[2] <= reg_req.wdata;
				`MCF_ADDR_TEST_ONE:     test_control_one  <= reg_req.wdata;
				default: begin
					if (in_bank(reg_req.addr, `MCF_ADDR_HIGH_BASE))
						high_lim[5'(reg_req.addr - `MCF_ADDR_HIGH_BASE)] <= reg_req.wdata;
					if (in_bank(reg_req.addr, `MCF_ADDR_LOW_BASE))
						low_lim[5'(reg_req.addr - `MCF_ADDR_LOW_BASE)] <= reg_req.wdata;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (clk_en && reg_req.rd) begin
			case (reg_req.addr)
				`MCF_ADDR_CONFIG_ONE:   reg_rdata <= config_one;
				`MCF_ADDR_DAC_CODE:     reg_rdata <= fan_dac_code;
				`MCF_ADDR_PWM_DUTY:     reg_rdata <= fan_pwm_duty;
				`MCF_ADDR_START_FIRST:  reg_rdata <= fan_start_temp[0];
				`MCF_ADDR_START_SECOND: reg_rdata <= fan_start_temp[1];
				`MCF_ADDR_START_THIRD:  reg_rdata <= fan_start_temp[2];
				`MCF_ADDR_TEST_ONE:     reg_rdata <= test_control_one;
				`MCF_ADDR_SHARED_A:     reg_rdata <= shared_analog_value;
				`MCF_ADDR_SHARED_B:     reg_rdata <= shared_temp_or_analog_value;
				`MCF_ADDR_STATUS:       reg_rdata <= {6'h00, status};
				default: begin
					if (in_bank(reg_req.addr, `MCF_ADDR_VALUE_BASE))
						reg_rdata <= value[5'(reg_req.addr - `MCF_ADDR_VALUE_BASE)];
					else if (in_bank(reg_req.addr, `MCF_ADDR_HIGH_BASE))
						reg_rdata <= high_lim[5'(reg_req.addr - `MCF_ADDR_HIGH_BASE)];
					else if (in_bank(reg_req.addr, `MCF_ADDR_LOW_BASE))
						reg_rdata <= low_lim[5'(reg_req.addr - `MCF_ADDR_LOW_BASE)];
					else
						reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	// ==========================================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_idle_needs_start: assert property (clk_en && state == mcf_pkg::MCF_SEQ_IDLE && !run
		|=> state == mcf_pkg::MCF_SEQ_IDLE) else $error("sequencer left idle without start");
	a_int_gated_enable: assert property ($past(clk_en) && !$past(config_one[`MCF_CFG_INT_EN])
		|-> !int_n_oe) else $error("interrupt pin driven while disabled");
	a_order_wraps_home: assert property (clk_en && state == mcf_pkg::MCF_SEQ_CONVERT && run &&
		slot_end && samp == `MCF_SAMPLES_LAST && adc_chan == `MCF_CH_LOCAL
		|=> adc_chan == `MCF_CH_REMOTE_ONE) else $error("local channel not followed by remote one");
	a_slot_length_ok: assert property (adc_sample && $past(clk_en)
		|-> $past(conv_cnt) == $past(slot_len) - 32'd1) else $error("conversion slot length wrong");
	a_avg_sixteen_ok: assert property (done && $past(clk_en) |-> samp == 4'h0 && adc_sample)
		else $error("result stored before sixteen samples");
	a_shared_discard: assert property (clk_en && done && done_ch == `MCF_CH_REMOTE_TWO &&
		!diode_mode |=> $stable(shared_temp_or_analog_value)) else $error("temperature stored in analog mode");
	a_spin_full_drive: assert property (clk_en && auto_dac && fan_on && spinning
		|=> dac_code == `MCF_FULL_DRIVE) else $error("no full drive during spin-up");
	a_dac_floor_min: assert property (clk_en && auto_dac && fan_on && !spinning && max_hold <= 9'sd0
		|=> dac_code == {$past(fan_dac_code[7:4]), 4'h0}) else $error("DAC floor not sixteen per step");
	a_fan_stop_cool: assert property (clk_en && $past(clk_en) && $fell(fan_on) && (auto_dac || auto_pwm)
		|-> $past(all_cool)) else $error("fan stopped before all sensors cooled");
	a_fan_event_flag: assert property (clk_en && fan_event |=> status[`MCF_STAT_FAN])
		else $error("fan start or stop not flagged");
	a_pwm_pin_polarity: assert property (clk_en |=> pwm_oe ==
		!($past(pwm_active) ^ $past(test_control_one[`MCF_TEST_PWM_INVERT])))
		else $error("pulse pin polarity wrong");

endmodule // mcf_monitor_fan
`default_nettype wire

// [sim/mcf_far_side.sv]
// Converter and open-drain pin model at the far side of the fan monitor
`timescale 1ns/1ps
`default_nettype none

module mcf_far_side (
	input  wire logic [4:0] adc_chan,  // Channel being converted
	input  wire logic       pwm_o,     // Pulse pin level when driven
	input  wire logic       pwm_oe,    // Pulse pin driven
	input  wire logic       int_n_o,   // Interrupt pin level when driven
	input  wire logic       int_n_oe,  // Interrupt pin driven
	output logic [7:0]      adc_data,  // Converter result
	output logic            pwm_pin,   // Resolved pulse pin
	output logic            int_n_pin  // Resolved interrupt pin
);
	// ==========================================================
	// Steady level per channel, set by the bench
	logic [7:0] level [0:19];

	assign adc_data = (adc_chan < 5'h14) ? level[adc_chan] : 8'h00;
	// Pull-ups: a released pin reads high
	assign pwm_pin = pwm_oe ? pwm_o : 1'b1;
	assign int_n_pin = int_n_oe ? int_n_o : 1'b1;
endmodule // mcf_far_side
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the monitor sequencer and automatic fan drive
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int unsigned FAST  = 4;
	localparam int unsigned SLOW  = 8;
	localparam int unsigned ROUND = (18 * FAST + 2 * SLOW) * 16 + 200;
	logic                  ref_clk = 1'b0;
	logic                  rst     = 1'b1;
	logic                  clk_en  = 1'b1;
	mcf_pkg::mcf_reg_req_t req     = '0;
	logic [7:0]            rdata, adc_data, dac_code;
	logic [4:0]            adc_chan;
	logic                  adc_sample, pwm_o, pwm_oe, int_n_o, int_n_oe, fan_running;
	logic                  pwm_pin, int_n_pin;
	int                    failures = 0;
	int                    checked  = 0;
	int                    n;
	logic [7:0]            lvl [0:19];

	always #12.5 ref_clk = ~ref_clk;

	mcf_monitor_fan #(.FAST_CONV_CYC(FAST), .SLOW_CONV_CYC(SLOW), .SPINUP_CYC(50)) mcf_monitor_fan_i (
		.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_req(req), .reg_rdata(rdata),
		.adc_data(adc_data), .adc_chan(adc_chan), .adc_sample(adc_sample), .dac_code(dac_code),
		.pwm_o(pwm_o), .pwm_oe(pwm_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
		.fan_running(fan_running));
	mcf_far_side mcf_far_side_i (.adc_chan(adc_chan), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
		.int_n_o(int_n_o), .int_n_oe(int_n_oe), .adc_data(adc_data), .pwm_pin(pwm_pin),
		.int_n_pin(int_n_pin));

	// ==========================================================
	// Reference model
	function automatic logic [7:0] avg16(input logic [7:0] s);
		int q[$];
		int sum;
		sum = 0;
		for (int i = 0; i < 16; i++) q.push_back($signed(s));
		foreach (q[i]) sum += q[i];
		return 8'(sum >>> 4);
	endfunction

	function automatic logic [7:0] law(input int floor, input int top, input int diff);
		if (diff > 20) return 8'hff;
		if (diff <= 0) return 8'(floor);
		return 8'(floor + (top - floor) * diff / 20);
	endfunction

	// ==========================================================
	// Bus and compare tasks
	task automatic tally_and_finish();
		$display("Mismatches %0d of %0d comparisons", failures, checked);
		if (failures == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge ref_clk);
		req = '0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge ref_clk);
		req = '0;
		@(negedge ref_clk);
		chk(rdata, exp);
	endtask

	// Bounded wait; running out ends the run as a mismatch
	task automatic wait_dac(input logic [7:0] v);
		for (n = 0; n < 3 * ROUND && dac_code !== v; n++) @(negedge ref_clk);
		if (n == 3 * ROUND) begin
			failures++;
			tally_and_finish();
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		n = $urandom(35749);
		for (int c = 0; c < 20; c++) lvl[c] = (c == 19) ? 8'h28 : 8'($urandom_range(112, 0));
		for (int c = 0; c < 20; c++) mcf_far_side_i.level[c] = lvl[c];
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		rd_chk(8'h04, 8'hff);
		rd_chk(8'h05, 8'hff);
		rd_chk(8'h10, 8'h7f);
		rd_chk(8'hf0, 8'h00);
		wr(8'h00, 8'h01);
		repeat (2 * ROUND) @(negedge ref_clk);
		for (int c = 0; c < 20; c++)
			if (c != 18) rd_chk(8'h30 + 8'(c), avg16(lvl[c]));
		rd_chk(8'h27, avg16(lvl[9]));
		rd_chk(8'h29, avg16(lvl[10]));
		// Temperatures above the reset hot limit of minus one degree
		rd_chk(8'h44, 8'h01);
		chk(8'(int_n_pin), 8'h01);
		chk(8'(pwm_pin), 8'h01);
		wr(8'h14, 8'h02);
		repeat (2) @(negedge ref_clk);
		chk(8'(pwm_pin), 8'h00);
		// Floor nibble 5, local reading ten degrees over start, both outputs automatic
		wr(8'h04, 8'h50);
		wr(8'h10, 8'h1e);
		wr(8'h00, 8'h63);
		wait_dac(8'hff);
		chk(8'(fan_running), 8'h01);
		@(negedge ref_clk);
		// Frozen enable must stretch the spin-up well past its count
		clk_en = 1'b0;
		repeat (100) @(negedge ref_clk);
		chk(dac_code, 8'hff);
		chk(8'(pwm_pin), 8'h00);
		clk_en = 1'b1;
		wait_dac(law(16 * 5, 240, 10));
		chk(8'(int_n_pin), 8'h00);
		rd_chk(8'h44, 8'h03);
		// Two degrees under start: inside the hysteresis band, floor drive, fan kept on
		wr(8'h10, 8'h2a);
		wait_dac(law(16 * 5, 240, -2));
		chk(8'(fan_running), 8'h01);
		wr(8'h10, 8'h7f);
		wait_dac(8'h00);
		chk(8'(fan_running), 8'h00);
		repeat (2) @(negedge ref_clk);
		chk(8'(pwm_pin), 8'h01);
		// Clear flags, lift temperature hot limits, trip one voltage low limit
		wr(8'h00, 8'h04);
		wr(8'h50, 8'h7f);
		wr(8'h62, 8'h7f);
		wr(8'h63, 8'h7f);
		wr(8'h71, lvl[1] + 8'h01);
		wr(8'h00, 8'h09);
		repeat (ROUND) @(negedge ref_clk);
		rd_chk(8'h29, avg16(lvl[18]));
		rd_chk(8'h44, 8'h01);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
